// >>> rtl/pulse_mod_cfg.svh
/*
  Constants of the pulse modulation timing generator: clock period, limits,
  reset values and derived cycle counts. Times are in nanoseconds and
  frequencies in millihertz. Assumes a single 250 MHz clock.
*/
`ifndef PULSE_MOD_CFG_SVH
`define PULSE_MOD_CFG_SVH

// ****************************************************************
// Clock and fixed trigger latency
// ****************************************************************
`define PM_CLK_PERIOD_NS  40'h0000000004
`define PM_TRIG_DELAY_NS  40'h0000000064
`define PM_TRIG_DELAY_CYC \
  ((`PM_TRIG_DELAY_NS + `PM_CLK_PERIOD_NS - 40'h1) / `PM_CLK_PERIOD_NS)

// ****************************************************************
// Limits
// ****************************************************************
`define PM_TIME_MAX_NS    40'h174876E800
`define PM_DSTEP_MAX_NS   40'h00000F4240
`define PM_PER_MIN_NAR_NS 40'h0000000028
`define PM_PER_MIN_STD_NS 40'h0000000078
`define PM_FREQ_MIN_MHZ   40'h000000000A
`define PM_FREQ_MAX_NAR   40'h05D21DBA00
`define PM_FREQ_MAX_STD   40'h01F0B49355
`define PM_FSTEP_MAX_MHZ  40'h05D21DBA00
`define PM_PCT_MIN        7'h02
`define PM_PCT_MAX        7'h64
`define PM_PCT_SCALE      47'h00000003E8
`define PM_WIDTH_MARGIN   40'h000000000A

// ****************************************************************
// Reset values
// ****************************************************************
`define PM_DELAY_RST      40'h0000000000
`define PM_DSTEP_RST      40'h000000000A
`define PM_FREQ_RST       40'h00000F4240
`define PM_FSTEP_RST      40'h00000F4240
`define PM_PERIOD_RST     40'h00000F4240
`define PM_WIDTH_RST      40'h0000002710
`define PM_PCT_RST        7'h0A
`define PM_LFSR_SEED      32'h0000ACE1

`endif

// >>> rtl/pulse_mod_pkg.sv
/*
  Types of the pulse modulation timing generator: sources, command codes
  and the per-channel setting record. Assumes pulse_mod_cfg.svh for values.
*/
`default_nettype none

package pulse_mod_pkg;

  typedef logic [39:0] pm_value_type;

  typedef enum logic [4:0] {
    SRC_AUTO   = 5'h01,
    SRC_SQUARE = 5'h02,
    SRC_DOUBLE = 5'h04,
    SRC_TRIG   = 5'h08,
    SRC_JITTER = 5'h10
  } pm_source_type;

  typedef enum logic [3:0] {
    OP_SET_DELAY  = 4'h0,
    OP_SET_DSTEP  = 4'h1,
    OP_DELAY_UP   = 4'h2,
    OP_DELAY_DOWN = 4'h3,
    OP_SET_FREQ   = 4'h4,
    OP_SET_FSTEP  = 4'h5,
    OP_FREQ_UP    = 4'h6,
    OP_FREQ_DOWN  = 4'h7,
    OP_SET_JMODE  = 4'h8,
    OP_SET_JPCT   = 4'h9,
    OP_SET_PERIOD = 4'hA,
    OP_SET_WIDTH  = 4'hB,
    OP_SET_SOURCE = 4'hC
  } pm_op_type;

  typedef struct packed {
    pm_value_type  delay;
    pm_value_type  delay_step;
    pm_value_type  freq;
    pm_value_type  freq_step;
    pm_value_type  period;
    pm_value_type  pulse_length;
    logic [6:0]    jit_pct;
    logic          jit_gauss;
    pm_source_type source;
  } pm_chan_cfg_type;

endpackage

`default_nettype wire

// >>> rtl/pulse_mod_timer.sv
/*
  One channel's pulse timer: builds the pulse from the channel settings.
  Assumes trigger input is already synchronised and a single clock.
*/
`include "pulse_mod_cfg.svh"
`default_nettype none

module pulse_mod_timer import pulse_mod_pkg::*; (
  // Clock and reset
  input  wire logic            ref_clk_in,
  input  wire logic            rst_in,
  // Settings
  input  wire pm_chan_cfg_type cfg_in,
  input  wire pm_value_type    jitter_in,
  input  wire logic            enable_in,
  input  wire logic            trig_in,
  // Output
  output logic                 pulse_out
);

  pm_value_type phase_q;
  pm_value_type period_eff_q;
  logic [7:0]   trig_cnt_q;
  logic         run_q;
  logic [40:0]  next_phase;
  logic [40:0]  rel;
  logic [40:0]  rel2;
  pm_value_type eff_delay;
  logic         trig_mode;
  logic         hi;

  assign trig_mode  = (cfg_in.source == SRC_TRIG);
  assign next_phase = {1'b0, phase_q} + {1'b0, `PM_CLK_PERIOD_NS};
  // Jittered pulses ignore the programmed delay.
  assign eff_delay  = (cfg_in.source == SRC_JITTER) ?
                      '0 : cfg_in.delay;
  assign rel        = {1'b0, phase_q} - {1'b0, eff_delay};
  assign rel2       = rel - {cfg_in.pulse_length, 1'b0};

  // ****************************************************************
  // Trigger latency and one-shot run
  // ****************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || !enable_in || !trig_mode) begin
      trig_cnt_q <= 8'h00;
      run_q      <= 1'b0;
    end else if (trig_in) begin
      trig_cnt_q <= 8'(`PM_TRIG_DELAY_CYC);
      run_q      <= 1'b0;
    end else if (trig_cnt_q != 8'h00) begin
      trig_cnt_q <= trig_cnt_q - 8'h01;
      run_q      <= (trig_cnt_q == 8'h01);
    end else if (run_q && (rel[40] == 1'b0) &&
                 (rel[39:0] >= cfg_in.pulse_length)) begin
      run_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Phase counter in nanoseconds
  // ****************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || !enable_in) begin
      phase_q      <= '0;
      period_eff_q <= `PM_PERIOD_RST;
    end else if (trig_mode) begin
      phase_q <= run_q ? next_phase[39:0] : '0;
    end else if (next_phase >= {1'b0, period_eff_q}) begin
      phase_q <= '0;
      // Only the period moves under jitter; the width is left alone.
      period_eff_q <= (cfg_in.source == SRC_JITTER) ?
                      cfg_in.period + jitter_in : cfg_in.period;
    end else begin
      phase_q <= next_phase[39:0];
    end
  end

  // ****************************************************************
  // Pulse shaping per source
  // ****************************************************************
  always_comb begin
    hi = 1'b0;
    unique case (cfg_in.source)
      SRC_AUTO:   hi = !rel[40] && (rel[39:0] < cfg_in.pulse_length);
      SRC_SQUARE: hi = !rel[40] && (rel[39:0] < {1'b0, period_eff_q[39:1]});
      SRC_DOUBLE: hi = (!rel[40] && (rel[39:0] < cfg_in.pulse_length)) ||
                       (!rel2[40] && (rel2[39:0] < cfg_in.pulse_length));
      SRC_TRIG:   hi = run_q && !rel[40] &&
                       (rel[39:0] < cfg_in.pulse_length);
      SRC_JITTER: hi = (phase_q < cfg_in.pulse_length);
      default:    hi = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= enable_in && hi;
    end
  end

endmodule // pulse_mod_timer

`default_nettype wire

// >>> rtl/pulse_modulation_timing_generator.sv
/*
  Pulse modulation timing generator: two channels of pulse settings kept
  behind a command port, range checked, and two pulse timers driven from
  them. Assumes option straps and trigger pins are asynchronous, and the
  command port is driven from logic on ref_clk_in.
*/
`include "pulse_mod_cfg.svh"
`default_nettype none

module pulse_modulation_timing_generator import pulse_mod_pkg::*; #(
  parameter int CHANNELS = 2
) (
  // Clock and reset
  input  wire logic            ref_clk_in,
  input  wire logic            rst_in,
  // Option straps (asynchronous levels)
  input  wire logic            pulse_mod_opt_in,
  input  wire logic            narrow_opt_in,
  // Command port
  input  wire logic            cmd_valid_in,
  input  wire logic            cmd_channel_in,
  input  wire pm_op_type       cmd_op_in,
  input  wire pm_value_type    cmd_value_in,
  output logic                 cmd_done_out,
  output logic                 cmd_undef_out,
  output logic                 cmd_range_out,
  // Trigger pins and pulse outputs
  input  wire logic [CHANNELS-1:0] trig_in,
  output logic [CHANNELS-1:0]      pulse_mod_out,
  // Settings read back
  output pm_chan_cfg_type          cfg_out [CHANNELS]
);

  // ****************************************************************
  // Synchronisers
  // ****************************************************************
  logic [1:0]          opt_meta_q;
  logic [1:0]          opt_q;
  logic [CHANNELS-1:0] trig_meta_q;
  logic [CHANNELS-1:0] trig_sync_q;
  logic [CHANNELS-1:0] trig_last_q;
  logic                pm_enable;
  logic                narrow;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      opt_meta_q  <= 2'h0;
      opt_q       <= 2'h0;
      trig_meta_q <= '0;
      trig_sync_q <= '0;
      trig_last_q <= '0;
    end else begin
      opt_meta_q  <= {narrow_opt_in, pulse_mod_opt_in};
      opt_q       <= opt_meta_q;
      trig_meta_q <= trig_in;
      trig_sync_q <= trig_meta_q;
      trig_last_q <= trig_sync_q;
    end
  end

  assign pm_enable = opt_q[0];
  assign narrow    = opt_q[1];

  // ****************************************************************
  // Command evaluation
  // ****************************************************************
  pm_chan_cfg_type cfg_q [CHANNELS];
  pm_chan_cfg_type cur;
  pm_chan_cfg_type nxt;
  logic            ok;
  logic            undef;
  logic [40:0]     sum;
  logic [40:0]     dif;
  pm_value_type    per_min;
  pm_value_type    freq_max;

  // Delay window depends on the source: period-bound, or trigger-bound.
  function automatic logic delay_ok(input pm_value_type v,
                                    input pm_chan_cfg_type c);
    logic r;
    if (c.source == SRC_TRIG) begin
      r = (v >= `PM_TRIG_DELAY_NS) && (v <= `PM_TIME_MAX_NS);
    end else begin
      r = (v <= c.period);
    end
    return r;
  endfunction

  function automatic logic freq_ok(input pm_value_type v,
                                   input pm_value_type fmax);
    return (v >= `PM_FREQ_MIN_MHZ) && (v <= fmax);
  endfunction

  assign per_min  = narrow ? `PM_PER_MIN_NAR_NS : `PM_PER_MIN_STD_NS;
  assign freq_max = narrow ? `PM_FREQ_MAX_NAR : `PM_FREQ_MAX_STD;

  always_comb begin
    cur   = cfg_q[cmd_channel_in];
    nxt   = cur;
    ok    = 1'b0;
    undef = 1'b0;
    sum   = 41'h0;
    dif   = 41'h0;
    case (cmd_op_in)
      OP_SET_DELAY: begin
        nxt.delay = cmd_value_in;
        ok        = delay_ok(cmd_value_in, cur);
      end
      OP_SET_DSTEP: begin
        nxt.delay_step = cmd_value_in;
        ok             = (cmd_value_in <= `PM_DSTEP_MAX_NS);
      end
      OP_DELAY_UP: begin
        sum       = {1'b0, cur.delay} + {1'b0, cur.delay_step};
        nxt.delay = sum[39:0];
        ok        = !sum[40] && delay_ok(sum[39:0], cur);
      end
      OP_DELAY_DOWN: begin
        dif       = {1'b0, cur.delay} - {1'b0, cur.delay_step};
        nxt.delay = dif[39:0];
        ok        = !dif[40] && delay_ok(dif[39:0], cur);
      end
      OP_SET_FREQ: begin
        nxt.freq = cmd_value_in;
        ok       = freq_ok(cmd_value_in, freq_max);
      end
      OP_SET_FSTEP: begin
        nxt.freq_step = cmd_value_in;
        ok            = (cmd_value_in <= `PM_FSTEP_MAX_MHZ);
      end
      OP_FREQ_UP: begin
        sum      = {1'b0, cur.freq} + {1'b0, cur.freq_step};
        nxt.freq = sum[39:0];
        ok       = !sum[40] && freq_ok(sum[39:0], freq_max);
      end
      OP_FREQ_DOWN: begin
        dif      = {1'b0, cur.freq} - {1'b0, cur.freq_step};
        nxt.freq = dif[39:0];
        ok       = !dif[40] && freq_ok(dif[39:0], freq_max);
      end
      OP_SET_JMODE: begin
        nxt.jit_gauss = cmd_value_in[0];
        ok            = (cmd_value_in[39:1] == 39'h0);
      end
      OP_SET_JPCT: begin
        nxt.jit_pct = cmd_value_in[6:0];
        ok          = (cmd_value_in >= 40'(`PM_PCT_MIN)) &&
                      (cmd_value_in <= 40'(`PM_PCT_MAX));
      end
      OP_SET_PERIOD: begin
        nxt.period = cmd_value_in;
        ok         = (cmd_value_in >= per_min) &&
                     (cmd_value_in <= `PM_TIME_MAX_NS);
        if (cur.pulse_length >= cmd_value_in) begin
          nxt.pulse_length = cmd_value_in - `PM_WIDTH_MARGIN;
        end
      end
      OP_SET_WIDTH: begin
        nxt.pulse_length = cmd_value_in;
        ok               = (cmd_value_in >= per_min) &&
                           (cmd_value_in < cur.period);
      end
      OP_SET_SOURCE: begin
        ok = 1'b1;
        unique case (cmd_value_in)
          40'h0:   nxt.source = SRC_AUTO;
          40'h1:   nxt.source = SRC_SQUARE;
          40'h2:   nxt.source = SRC_DOUBLE;
          40'h3:   nxt.source = SRC_TRIG;
          40'h4:   nxt.source = SRC_JITTER;
          default: ok = 1'b0;
        endcase
      end
      default: undef = 1'b1;
    endcase
  end

  // ****************************************************************
  // Settings store
  // ****************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < CHANNELS; i++) begin
        cfg_q[i].delay        <= `PM_DELAY_RST;
        cfg_q[i].delay_step   <= `PM_DSTEP_RST;
        cfg_q[i].freq         <= `PM_FREQ_RST;
        cfg_q[i].freq_step    <= `PM_FSTEP_RST;
        cfg_q[i].period       <= `PM_PERIOD_RST;
        cfg_q[i].pulse_length <= `PM_WIDTH_RST;
        cfg_q[i].jit_pct      <= `PM_PCT_RST;
        cfg_q[i].jit_gauss    <= 1'b0;
        cfg_q[i].source       <= SRC_AUTO;
      end
    end else if (cmd_valid_in && pm_enable && !undef && ok) begin
      cfg_q[cmd_channel_in] <= nxt;
    end
  end

  // ****************************************************************
  // Command answers
  // ****************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cmd_done_out  <= 1'b0;
      cmd_undef_out <= 1'b0;
      cmd_range_out <= 1'b0;
    end else begin
      cmd_done_out  <= cmd_valid_in;
      cmd_undef_out <= cmd_valid_in && (!pm_enable || undef);
      cmd_range_out <= cmd_valid_in && pm_enable && !undef && !ok;
    end
  end

  // ****************************************************************
  // Jitter source
  // ****************************************************************
  logic [31:0] lfsr_q;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      lfsr_q <= `PM_LFSR_SEED;
    end else begin
      lfsr_q <= {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^
                 lfsr_q[0]};
    end
  end

  // ****************************************************************
  // Channel timers
  // ****************************************************************
  for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
    logic [15:0]  frac;
    logic [9:0]   gsum;
    logic [46:0]  prod;
    pm_value_type amp;
    logic [55:0]  ext;

    // The percentage scales a window of a tenth of the period. The
    // Gaussian shape is a sum of four bytes: cheap and bell-like.
    assign gsum = 10'(lfsr_q[7:0]) + 10'(lfsr_q[15:8]) +
                  10'(lfsr_q[23:16]) + 10'(lfsr_q[31:24]);
    assign frac = cfg_q[c].jit_gauss ? {gsum, 6'h00} : lfsr_q[15:0];
    assign prod = 47'(cfg_q[c].period) * 47'(cfg_q[c].jit_pct);
    assign amp  = 40'(prod / `PM_PCT_SCALE);
    assign ext  = 56'(amp) * 56'(frac);

    pulse_mod_timer u_timer (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .cfg_in     (cfg_q[c]),
      .jitter_in  (ext[55:16]),
      .enable_in  (pm_enable),
      .trig_in    (trig_sync_q[c] && !trig_last_q[c]),
      .pulse_out  (pulse_mod_out[c])
    );

    assign cfg_out[c] = cfg_q[c];
  end

endmodule // pulse_modulation_timing_generator

`default_nettype wire

// >>> sim/pm_gen_assertions.sv
/*
  Checker for the pulse modulation generator command port and settings.
  Assumes a bind into the top module, one clock and a synchronous reset.
*/
`include "pulse_mod_cfg.svh"
`default_nettype none

module pm_gen_assertions import pulse_mod_pkg::*; #(
  parameter int CHANNELS = 2
) (
  // Clock, reset and strap
  input wire logic                ref_clk_in,
  input wire logic                rst_in,
  input wire logic                pulse_mod_opt_in,
  // Command port
  input wire logic                cmd_valid_in,
  input wire logic                cmd_channel_in,
  input wire pm_op_type           cmd_op_in,
  input wire pm_value_type        cmd_value_in,
  input wire logic                cmd_undef_out,
  input wire logic                cmd_range_out,
  // Outputs
  input wire logic [CHANNELS-1:0] pulse_mod_out,
  input wire pm_chan_cfg_type     cfg_out [CHANNELS]
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  // The strap passes two flops, so only a long-stable strap is trusted.
  logic [2:0]      opt_q;
  logic            go;
  pm_chan_cfg_type c;
  pm_value_type    up_v;
  always_ff @(posedge ref_clk_in) opt_q <= {opt_q[1:0], pulse_mod_opt_in};
  assign c = cfg_out[cmd_channel_in];
  assign go = cmd_valid_in && (&opt_q) && pulse_mod_opt_in;
  assign up_v = c.delay + c.delay_step;

  chk_undef_noopt: assert property (
    (!pulse_mod_opt_in)[*4] ##0 cmd_valid_in |=> cmd_undef_out)
    else $error("command taken without option");
  chk_undef_opcode: assert property (
    cmd_valid_in && cmd_op_in > OP_SET_SOURCE |=> cmd_undef_out)
    else $error("bad op code not refused");
  chk_refuse_keep: assert property (
    cmd_undef_out || cmd_range_out |->
      cfg_out[0] == $past(cfg_out[0]) && cfg_out[1] == $past(cfg_out[1]))
    else $error("refused command changed settings");
  chk_delay_limit: assert property (
    go && cmd_op_in == OP_SET_DELAY && c.source != SRC_TRIG &&
      cmd_value_in > c.period |=> cmd_range_out)
    else $error("delay above period accepted");
  chk_dstep_limit: assert property (
    go && cmd_op_in == OP_SET_DSTEP && cmd_value_in > `PM_DSTEP_MAX_NS
      |=> cmd_range_out)
    else $error("delay step above limit accepted");
  chk_jpct_limit: assert property (
    go && cmd_op_in == OP_SET_JPCT &&
      (cmd_value_in < 40'h2 || cmd_value_in > 40'h64) |=> cmd_range_out)
    else $error("jitter percent out of range accepted");
  chk_freq_limit: assert property (
    go && cmd_op_in == OP_SET_FREQ && (cmd_value_in < `PM_FREQ_MIN_MHZ ||
      cmd_value_in > `PM_FREQ_MAX_NAR) |=> cmd_range_out)
    else $error("frequency out of range accepted");
  chk_width_shrink: assert property (
    go && cmd_op_in == OP_SET_PERIOD && cmd_value_in >= `PM_PER_MIN_STD_NS
      && cmd_value_in <= `PM_TIME_MAX_NS && cmd_value_in <= c.pulse_length
      |=> cfg_out[$past(cmd_channel_in)].pulse_length < $past(cmd_value_in))
    else $error("width not reduced below new period");
  chk_delay_step: assert property (
    go && cmd_op_in == OP_DELAY_UP && c.source != SRC_TRIG &&
      up_v <= c.period |=> cfg_out[$past(cmd_channel_in)].delay == $past(up_v))
    else $error("delay up did not add the step");
  chk_chan_apart: assert property (
    cmd_valid_in && cmd_channel_in |=> cfg_out[0] == $past(cfg_out[0]))
    else $error("channel one command changed channel zero");
  chk_reset_vals: assert property (
    $fell(rst_in) |-> cfg_out[0].period == `PM_PERIOD_RST &&
      cfg_out[0].delay == `PM_DELAY_RST && cfg_out[0].source == SRC_AUTO)
    else $error("settings not at reset values");

  cover property (cmd_range_out);
  cover property (cmd_undef_out);
  cover property ($rose(pulse_mod_out[1]));
endmodule // pm_gen_assertions

bind pulse_modulation_timing_generator pm_gen_assertions #(
  .CHANNELS(CHANNELS)
) pm_gen_assertions_inst (
  .ref_clk_in(ref_clk_in),
  .rst_in(rst_in),
  .pulse_mod_opt_in(pulse_mod_opt_in),
  .cmd_valid_in(cmd_valid_in),
  .cmd_channel_in(cmd_channel_in),
  .cmd_op_in(cmd_op_in),
  .cmd_value_in(cmd_value_in),
  .cmd_undef_out(cmd_undef_out),
  .cmd_range_out(cmd_range_out),
  .pulse_mod_out(pulse_mod_out),
  .cfg_out(cfg_out)
);

`default_nettype wire

// >>> sim/pm_host_model.sv
/*
  Host model: issues one command per call as a one-cycle strobe.
  Assumes the generator answers one cycle after the strobe.
*/
`default_nettype none

module pm_host_model import pulse_mod_pkg::*; (
  // Clock and answers
  input  wire logic   ref_clk_in,
  input  wire logic   done_in,
  input  wire logic   undef_in,
  input  wire logic   range_in,
  // Command
  output logic         valid_out,
  output logic         chan_out,
  output pm_op_type    op_out,
  output pm_value_type value_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    valid_out = 1'b0;
    chan_out = 1'b0;
    op_out = OP_SET_DELAY;
    value_out = 40'h0;
  end

  // The value is inverted when idle so a stale value is never trusted.
  task automatic issue(input logic ch, input pm_op_type op,
                       input pm_value_type v, output logic [2:0] rsp);
    @(posedge ref_clk_in);
    valid_out <= 1'b1;
    chan_out <= ch;
    op_out <= op;
    value_out <= v;
    @(posedge ref_clk_in);
    valid_out <= 1'b0;
    value_out <= ~v;
    #1 rsp = {done_in, undef_in, range_in};
  endtask
endmodule // pm_host_model

`default_nettype wire

// >>> sim/testbench.sv
/*
  Testbench of the pulse modulation generator: command sequences with
  expected answers and settings. Assumes a 250 MHz clock; the narrow strap
  is on until the last test.
*/
`include "pulse_mod_cfg.svh"
`default_nettype none

module testbench import pulse_mod_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] OK = 3'h4;
  localparam logic [2:0] UND = 3'h6;
  localparam logic [2:0] RNG = 3'h5;
  logic ref_clk, rst, opt, nar, valid, ch, done, undef, range;
  logic [1:0]      trig;
  logic [1:0]      pulse;
  pm_op_type       op;
  pm_value_type    val;
  pm_chan_cfg_type cfg [2];
  int              err_total, cmp_count, n;

  pulse_modulation_timing_generator #(.CHANNELS(2))
  pulse_modulation_timing_generator_inst (
    .ref_clk_in(ref_clk), .rst_in(rst), .pulse_mod_opt_in(opt),
    .narrow_opt_in(nar), .cmd_valid_in(valid), .cmd_channel_in(ch),
    .cmd_op_in(op), .cmd_value_in(val), .cmd_done_out(done),
    .cmd_undef_out(undef), .cmd_range_out(range), .trig_in(trig),
    .pulse_mod_out(pulse), .cfg_out(cfg));
  pm_host_model pm_host_model_inst (
    .ref_clk_in(ref_clk), .done_in(done), .undef_in(undef),
    .range_in(range), .valid_out(valid), .chan_out(ch), .op_out(op),
    .value_out(val));

  // ****************************************************************
  // Compare and command tasks
  // ****************************************************************
  task automatic cmp_val(input pm_value_type got, input pm_value_type exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_rsp(input logic [2:0] got, input logic [2:0] exp);
    cmp_val({37'h0, got}, {37'h0, exp});
  endtask
  task automatic cmd(input logic c, input pm_op_type o,
                     input pm_value_type v, input logic [2:0] e);
    logic [2:0] r;
    pm_host_model_inst.issue(c, o, v, r);
    cmp_rsp(r, e);
  endtask
  function automatic pm_value_type fld(pm_chan_cfg_type c, pm_op_type o);
    case (o)
      OP_SET_DELAY: return c.delay;
      OP_SET_DSTEP: return c.delay_step;
      OP_SET_FREQ: return c.freq;
      OP_SET_FSTEP: return c.freq_step;
      OP_SET_JPCT: return {33'h0, c.jit_pct};
      default: return c.period;
    endcase
  endfunction
  // A refused command must leave the field as it was before.
  task automatic try(input logic c, input pm_op_type o,
                     input pm_value_type v, input logic [2:0] e);
    pm_value_type old;
    old = fld(cfg[c], o);
    cmd(c, o, v, e);
    cmp_val(fld(cfg[c], o), (e == OK) ? v : old);
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Clock, watchdog and tests
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    opt = 1'b0;
    nar = 1'b1;
    trig = 2'h0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 2; i++) begin
      cmp_val(cfg[i].delay, `PM_DELAY_RST);
      cmp_val(cfg[i].delay_step, `PM_DSTEP_RST);
      cmp_val(cfg[i].freq, `PM_FREQ_RST);
      cmp_val(cfg[i].freq_step, `PM_FSTEP_RST);
      cmp_val(cfg[i].period, `PM_PERIOD_RST);
      cmp_val({33'h0, cfg[i].jit_pct}, 40'hA);
      cmp_val({39'h0, cfg[i].jit_gauss}, 40'h0);
      cmp_val({35'h0, cfg[i].source}, {35'h0, SRC_AUTO});
    end
    $display("test reset_values done");
    try(1'b0, OP_SET_JPCT, 40'h5, UND);
    cmp_val({39'h0, pulse[0]}, 40'h0);
    @(posedge ref_clk);
    opt <= 1'b1;
    repeat (3) @(posedge ref_clk);
    try(1'b0, pm_op_type'(4'hD), 40'h5, UND);
    cmp_val({39'h0, pulse[0]}, 40'h1);
    $display("test option done");
    try(1'b0, OP_SET_DSTEP, `PM_DSTEP_MAX_NS + 40'h1, RNG);
    try(1'b0, OP_SET_DSTEP, `PM_DSTEP_MAX_NS, OK);
    try(1'b0, OP_SET_JPCT, 40'h1, RNG);
    try(1'b0, OP_SET_JPCT, 40'h65, RNG);
    try(1'b0, OP_SET_JPCT, 40'h2, OK);
    try(1'b0, OP_SET_JPCT, 40'h64, OK);
    try(1'b0, OP_SET_FREQ, 40'h9, RNG);
    try(1'b0, OP_SET_FREQ, `PM_FREQ_MAX_NAR + 40'h1, RNG);
    try(1'b0, OP_SET_FREQ, `PM_FREQ_MAX_NAR, OK);
    try(1'b0, OP_SET_FSTEP, `PM_FSTEP_MAX_MHZ + 40'h1, RNG);
    try(1'b0, OP_SET_DELAY, `PM_PERIOD_RST + 40'h1, RNG);
    try(1'b0, OP_SET_DELAY, `PM_PERIOD_RST, OK);
    try(1'b0, OP_SET_PERIOD, 40'h27, RNG);
    try(1'b0, OP_SET_PERIOD, `PM_TIME_MAX_NS + 40'h1, RNG);
    $display("test ranges done");
    try(1'b0, OP_SET_DELAY, 40'h64, OK);
    try(1'b0, OP_SET_DSTEP, 40'hFA, OK);
    cmd(1'b0, OP_DELAY_UP, 40'h0, OK);
    cmp_val(cfg[0].delay, 40'h15E);
    cmd(1'b0, OP_DELAY_DOWN, 40'h0, OK);
    cmp_val(cfg[0].delay, 40'h64);
    cmd(1'b0, OP_DELAY_DOWN, 40'h0, RNG);
    try(1'b0, OP_SET_FREQ, 40'h4C4B40, OK);
    try(1'b0, OP_SET_FSTEP, 40'h7D0, OK);
    cmd(1'b0, OP_FREQ_UP, 40'h0, OK);
    cmp_val(cfg[0].freq, 40'h4C5310);
    cmd(1'b0, OP_FREQ_DOWN, 40'h0, OK);
    cmp_val(cfg[0].freq, 40'h4C4B40);
    $display("test steps done");
    try(1'b1, OP_SET_JPCT, 40'h32, OK);
    cmp_val({33'h0, cfg[0].jit_pct}, 40'h64);
    cmd(1'b0, OP_SET_JMODE, 40'h1, OK);
    cmp_val({39'h0, cfg[0].jit_gauss}, 40'h1);
    cmp_val({39'h0, cfg[1].jit_gauss}, 40'h0);
    try(1'b1, OP_SET_PERIOD, 40'h1388, OK);
    cmp_val(cfg[1].pulse_length, 40'h137E);
    $display("test channels done");
    cmd(1'b1, OP_SET_SOURCE, 40'h3, OK);
    try(1'b1, OP_SET_DELAY, 40'h32, RNG);
    try(1'b1, OP_SET_DELAY, 40'h64, OK);
    @(posedge ref_clk);
    trig <= 2'h2;
    n = 0;
    while (pulse[1] !== 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    // Built-in 100 ns plus programmed 100 ns, with sync and register slack.
    cmp_val({39'h0, n >= 50 && n <= 58}, 40'h1);
    n = 0;
    while (pulse[1] === 1'b1 && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
    // A 4990 ns width spans 1248 cycles of 4 ns, the last one partial.
    cmp_val(40'(n), 40'h4E0);
    @(posedge ref_clk);
    trig <= 2'h0;
    $display("test trigger done");
    nar <= 1'b0;
    repeat (3) @(posedge ref_clk);
    try(1'b0, OP_SET_PERIOD, 40'h77, RNG);
    try(1'b0, OP_SET_PERIOD, 40'h78, OK);
    try(1'b0, OP_SET_FREQ, `PM_FREQ_MAX_STD + 40'h1, RNG);
    try(1'b0, OP_SET_FREQ, `PM_FREQ_MAX_STD, OK);
    cmd(1'b1, OP_SET_WIDTH, 40'h1388, RNG);
    cmp_val(cfg[1].pulse_length, 40'h137E);
    cmd(1'b1, OP_SET_SOURCE, 40'h5, RNG);
    cmp_val({35'h0, cfg[1].source}, {35'h0, SRC_TRIG});
    $display("test narrow done");
    wrap_up();
  end
endmodule // testbench

`default_nettype wire
